// [rtl/ccce_exec.sv]
// decode and execute of the clear, watchdog clear, complement and compare group
// assumes fetch holds instrWord stable through Q1 and data memory answers a
// read strobe with data in the following clock
`timescale 1ns/10ps

// What this block does
// RULE1: clear file, s=0 also clears working register
// RULE2: fixed watchdog clear word, one cycle
// RULE3: watchdog clear resets count, sets both flags
// RULE4: complement file, only zero flag updated
// RULE5: complement destination bit picks working or file
// RULE6: decode compare-equal opcode, no flag change
// RULE7: equal compare skips next on match
// RULE8: decode compare-greater opcode, no flag change
// RULE9: greater compare skips when file larger
// RULE10: skip forces nop, compare takes two cycles
// RULE11: unsigned subtraction only decides skip
// RULE12: decode, read, execute, write over phases
module ccce_exec #(
    parameter int unsigned DATA_W = 8,
    parameter int unsigned ADDR_W = 8
) (
    input wire logic clk_sys,
    input wire logic nrst,
    // fetch side
    input wire logic [15:0] instrWord,
    // data memory side
    input wire logic [DATA_W-1:0] dataRdata,
    output logic [ADDR_W-1:0] dataAddr,
    output logic dataRdEn,
    output logic dataWrEn,
    output logic [DATA_W-1:0] dataWdata,
    // core state
    output logic [DATA_W-1:0] workingReg,
    output logic zeroFlag,
    output logic timeoutFlagN,
    output logic powerdownFlagN,
    output logic watchdogClear,
    output logic skipNext,
    output ccce_pkg::ccce_phase_t phase,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata
);
    import ccce_pkg::*;

    // ------------------------------------------------------------ decode
    // classify one instruction word
    function automatic ccce_op_t decodeOp(input logic [15:0] w);
        ccce_op_t op;
        op = OP_OUTSIDE;
        if (w == WATCHDOG_CLEAR_WORD) begin
            op = OP_WATCHDOG_CLEAR;
        end else if (w[15:9] == CLEAR_FILE_TOP7) begin
            op = OP_CLEAR_FILE;
        end else if (w[15:9] == COMPLEMENT_TOP7) begin
            op = OP_COMPLEMENT;
        end else if (w[15:8] == CMP_EQUAL_TOP8) begin
            op = OP_CMP_EQUAL;
        end else if (w[15:8] == CMP_GREATER_TOP8) begin
            op = OP_CMP_GREATER;
        end
        return op;
    endfunction

    // ------------------------------------------------------------ state
    ccce_phase_t phaseNow; // phase from the sequencer
    logic cycleStart; // high in Q1
    ccce_op_t op_ff; // operation of this cycle
    ccce_op_t nxt_op;
    logic [ADDR_W-1:0] addr_ff; // file address of this cycle
    logic selBit_ff; // s or d bit
    logic skip_ff; // next instruction to be discarded
    logic nxt_skip;
    logic rdEn_ff; // read strobe
    logic wrEn_ff; // write strobe
    logic [DATA_W-1:0] wdata_ff; // write data
    logic [DATA_W-1:0] work_ff; // working register
    logic [DATA_W-1:0] nxt_work;
    logic zero_ff; // zero flag
    logic nxt_zero;
    logic timeoutN_ff; // timeout flag, active low
    logic nxt_timeoutN;
    logic powerdownN_ff; // power-down flag, active low
    logic nxt_powerdownN;
    logic wdClr_ff; // watchdog clear pulse
    logic [7:0] ctrl_ff; // control register
    logic [7:0] rdata_ff; // register read data
    logic [3:0] last_ff; // last executed op and skip
    logic [DATA_W-1:0] result_ff; // execute result held for Q4
    logic destWork_ff; // result goes to working register

    // sequencer instance
    ccce_phase_gen u_phase (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .phase(phaseNow),
        .cycleStart(cycleStart)
    );

    // ------------------------------------------------------------ decode wires
    logic runEnable; // control run bit
    ccce_op_t decoded; // op seen on the fetch word
    assign runEnable = ctrl_ff[CTRL_RUN_POS];
    assign decoded = decodeOp(instrWord);
    // discarded slot or stopped core becomes a forced nop
    assign nxt_op = (skip_ff || !runEnable) ? OP_NONE : decoded; // RULE10

    // phase strobes
    // exactly one of them is high in any clock
    logic inQ1;
    logic inQ2;
    logic inQ3;
    logic inQ4;
    assign inQ1 = cycleStart;
    assign inQ2 = (phaseNow == PH_Q2);
    assign inQ3 = (phaseNow == PH_Q3);
    assign inQ4 = (phaseNow == PH_Q4);

    // ------------------------------------------------------------ execute wires
    logic isClear;
    logic isWdClr;
    logic isComp;
    logic isCmpEq;
    logic isCmpGt;
    logic isCompare;
    logic needsRead;
    assign isClear = (op_ff == OP_CLEAR_FILE);
    assign isWdClr = (op_ff == OP_WATCHDOG_CLEAR);
    assign isComp = (op_ff == OP_COMPLEMENT);
    assign isCmpEq = (op_ff == OP_CMP_EQUAL);
    assign isCmpGt = (op_ff == OP_CMP_GREATER);
    assign isCompare = isCmpEq || isCmpGt;
    // file read in Q2 for every op with a file operand
    assign needsRead = isClear || isComp || isCompare;

    // unsigned difference, file minus working register
    // never stored, and no status flag ever sees it
    logic [DATA_W:0] diff;
    logic cmpEqual;
    logic cmpGreater;
    assign diff = {1'b0, dataRdata} - {1'b0, work_ff}; // RULE11
    assign cmpEqual = (diff == '0); // RULE11
    // no borrow and nonzero means file is larger
    assign cmpGreater = !diff[DATA_W] && !cmpEqual; // RULE11

    // skip decision taken in Q3
    // a skipped slot decodes as nop, so it can never skip again
    logic takeSkip;
    assign takeSkip = (isCmpEq && cmpEqual) || (isCmpGt && cmpGreater); // RULE7 RULE9

    // complement value and its zero test
    logic [DATA_W-1:0] compValue;
    assign compValue = ~dataRdata; // RULE4

    // execute result, zero for the clear op
    logic [DATA_W-1:0] execValue;
    assign execValue = isComp ? compValue : '0; // RULE1

    // destinations
    logic toWork;
    logic toFile;
    // clear: file always, working register when s is 0
    // complement: d picks one of the two
    assign toWork = (isClear && !selBit_ff) || (isComp && !selBit_ff); // RULE1 RULE5
    assign toFile = isClear || (isComp && selBit_ff); // RULE1 RULE5

    // ------------------------------------------------------------ register port decode
    logic hitWork;
    logic hitStatus;
    logic hitLast;
    logic hitCtrl;
    assign hitWork = (regAddr == REG_WORK_OFS);
    assign hitStatus = (regAddr == REG_STATUS_OFS);
    assign hitLast = (regAddr == REG_LAST_OFS);
    assign hitCtrl = (regAddr == REG_CTRL_OFS);

    logic swWork;
    logic swStatus;
    logic swCtrl;
    assign swWork = regWrite && hitWork;
    assign swStatus = regWrite && hitStatus;
    assign swCtrl = regWrite && hitCtrl;

    // status byte as seen by software
    logic [7:0] statusByte;
    assign statusByte = {5'b0_0000, powerdownN_ff, timeoutN_ff, zero_ff};

    // read mux, unmapped offsets read zero
    // offset 2 is read only: no write strobe decodes it
    logic [7:0] rdMux;
    assign rdMux = hitWork ? 8'(work_ff) :
                   hitStatus ? statusByte :
                   hitLast ? {4'h0, last_ff} :
                   hitCtrl ? ctrl_ff : 8'h00;

    // ------------------------------------------------------------ next state
    // instruction writes win over a software write in the same clock
    // so a Q4 result is never lost to a register port write
    assign nxt_work = (inQ4 && destWork_ff) ? result_ff :
                      swWork ? DATA_W'(regWdata) : work_ff; // RULE12

    // zero flag follows complement result only
    assign nxt_zero = (inQ3 && isComp) ? (compValue == '0) : // RULE4
                      swStatus ? regWdata[ST_ZERO_POS] : zero_ff;

    // both low-active flags forced high by watchdog clear
    assign nxt_timeoutN = (inQ3 && isWdClr) ? 1'b1 : // RULE3
                          swStatus ? regWdata[ST_TIMEOUT_POS] : timeoutN_ff;
    assign nxt_powerdownN = (inQ3 && isWdClr) ? 1'b1 : // RULE3
                            swStatus ? regWdata[ST_POWERDOWN_POS] : powerdownN_ff;

    // skip is armed in Q3 and consumed at the next Q1
    assign nxt_skip = (inQ3 && takeSkip) ? 1'b1 : // RULE10
                      inQ1 ? 1'b0 : skip_ff;

    // ------------------------------------------------------------ Q1 decode
    // latch operation, address and select bit
    // fetch must hold the word until the edge that ends Q1
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            op_ff <= OP_NONE;
            addr_ff <= '0;
            selBit_ff <= 1'b0;
        end else if (inQ1) begin
            op_ff <= nxt_op; // RULE2 RULE6 RULE8 RULE12
            addr_ff <= instrWord[ADDR_W-1:0]; // RULE6 RULE8
            selBit_ff <= instrWord[SEL_BIT_POS];
        end
    end

    // ------------------------------------------------------------ Q2 operand read
    // read strobe stands for the whole of Q2, data captured by Q3
    // watchdog clear and outside opcodes leave data memory alone
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rdEn_ff <= 1'b0;
        end else begin
            rdEn_ff <= inQ1 && (nxt_op != OP_NONE) && (nxt_op != OP_OUTSIDE) &&
                       (nxt_op != OP_WATCHDOG_CLEAR); // RULE12
        end
    end

    // ------------------------------------------------------------ Q3 execute
    // hold result and destinations for the write phase
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            result_ff <= '0;
            destWork_ff <= 1'b0;
        end else if (inQ3) begin
            result_ff <= execValue;
            destWork_ff <= toWork && needsRead;
        end
    end

    // ------------------------------------------------------------ Q4 write
    // write strobe and data stand for the whole of Q4
    // write data hold afterwards, so a slow memory sees a steady word
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wrEn_ff <= 1'b0;
            wdata_ff <= '0;
        end else begin
            wrEn_ff <= inQ3 && toFile; // RULE1 RULE5 RULE12
            wdata_ff <= inQ3 ? execValue : wdata_ff;
        end
    end

    // ------------------------------------------------------------ watchdog clear
    // one-clock pulse in Q4, resets count and postscaler outside
    // the two low-active flags were already set at the end of Q3
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wdClr_ff <= 1'b0;
        end else begin
            wdClr_ff <= inQ3 && isWdClr; // RULE2 RULE3
        end
    end

    // ------------------------------------------------------------ core state
    // working register, status flags and skip marker
    // reset drops a pending skip, so no slot is lost after it
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            work_ff <= DATA_W'(WORK_RST);
            zero_ff <= ZERO_RST;
            timeoutN_ff <= TIMEOUT_N_RST;
            powerdownN_ff <= POWERDOWN_N_RST;
            skip_ff <= 1'b0;
        end else begin
            work_ff <= nxt_work;
            zero_ff <= nxt_zero;
            timeoutN_ff <= nxt_timeoutN;
            powerdownN_ff <= nxt_powerdownN;
            skip_ff <= nxt_skip;
        end
    end

    // ------------------------------------------------------------ last op record
    // op code in low bits, skip taken above it
    // software reads back what Q3 decided, a taken skip included
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            last_ff <= 4'h0;
        end else if (inQ3) begin
            last_ff <= {takeSkip, op_ff};
        end
    end

    // ------------------------------------------------------------ register port
    // control register write
    // bit 0 gates execution; upper bits are kept for software only
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ctrl_ff <= CTRL_RST;
        end else if (swCtrl) begin
            ctrl_ff <= regWdata;
        end
    end

    // read data valid in the clock after the read strobe only
    // zero outside the answer cycle keeps a shared read bus quiet
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= regRead ? rdMux : 8'h00;
        end
    end

    // ------------------------------------------------------------ outputs
    assign dataAddr = addr_ff;
    assign dataRdEn = rdEn_ff;
    assign dataWrEn = wrEn_ff;
    assign dataWdata = wdata_ff;
    assign workingReg = work_ff;
    assign zeroFlag = zero_ff;
    assign timeoutFlagN = timeoutN_ff;
    assign powerdownFlagN = powerdownN_ff;
    assign watchdogClear = wdClr_ff;
    assign skipNext = skip_ff;
    assign phase = phaseNow;
    assign regRdata = rdata_ff;

endmodule

// [rtl/ccce_phase_gen.sv]
// four-phase instruction cycle sequencer
// assumes every clk_sys edge advances one phase
`timescale 1ns/10ps
module ccce_phase_gen (
    input wire logic clk_sys,
    input wire logic nrst,
    output ccce_pkg::ccce_phase_t phase,
    output logic cycleStart
);
    import ccce_pkg::*;

    ccce_phase_t phase_ff; // current phase
    ccce_phase_t nxt_phase; // following phase

    // wrap Q4 back to Q1
    assign nxt_phase = ccce_phase_t'(phase_ff + 2'b01);
    assign phase = phase_ff;
    // high during the decode phase
    assign cycleStart = (phase_ff == PH_Q1);

    // phase counter
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            phase_ff <= PH_Q1;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

endmodule

// [rtl/ccce_pkg.sv]
// constants and types shared by the clear/complement/compare execution block
// assumes a single 10 MHz core clock and a plain strobe register port
package ccce_pkg;

    // clock rate of clk_sys in hertz
    localparam int unsigned CLK_HZ = 10_000_000;

    // instruction cycle phases, one clock each
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00, // decode
        PH_Q2 = 2'b01, // operand read
        PH_Q3 = 2'b10, // execute
        PH_Q4 = 2'b11  // write back
    } ccce_phase_t;

    // decoded operations of this group
    typedef enum logic [2:0] {
        OP_NONE = 3'b000, // forced no-operation or reset value
        OP_CLEAR_FILE = 3'b001, // clear_file_op
        OP_WATCHDOG_CLEAR = 3'b010, // watchdog_clear_op
        OP_COMPLEMENT = 3'b011, // complement_file_op
        OP_CMP_EQUAL = 3'b100, // compare_skip_equal_op
        OP_CMP_GREATER = 3'b101, // compare_skip_greater_op
        OP_OUTSIDE = 3'b110 // instruction of another group
    } ccce_op_t;

    // opcode patterns
    localparam logic [6:0] CLEAR_FILE_TOP7 = 7'h14; // 0010_100s
    localparam logic [6:0] COMPLEMENT_TOP7 = 7'h09; // 0001_001d
    localparam logic [7:0] CMP_EQUAL_TOP8 = 8'h31; // 0011_0001
    localparam logic [7:0] CMP_GREATER_TOP8 = 8'h32; // 0011_0010
    localparam logic [15:0] WATCHDOG_CLEAR_WORD = 16'h0004;
    localparam int unsigned SEL_BIT_POS = 8; // s or d bit of the word

    // register port offsets
    localparam logic [3:0] REG_WORK_OFS = 4'h0;
    localparam logic [3:0] REG_STATUS_OFS = 4'h1;
    localparam logic [3:0] REG_LAST_OFS = 4'h2;
    localparam logic [3:0] REG_CTRL_OFS = 4'h3;

    // status field positions
    localparam int unsigned ST_ZERO_POS = 0;
    localparam int unsigned ST_TIMEOUT_POS = 1;
    localparam int unsigned ST_POWERDOWN_POS = 2;
    // control field positions
    localparam int unsigned CTRL_RUN_POS = 0;
    // last-op field positions
    localparam int unsigned LAST_SKIP_POS = 3;

    // values after reset
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h01;
    localparam logic ZERO_RST = 1'b0;
    localparam logic TIMEOUT_N_RST = 1'b1;
    localparam logic POWERDOWN_N_RST = 1'b1;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

endpackage

// [tb/ccce_exec_checker.sv]
// assertions on the ports of ccce_exec
// assumes it is bound into every ccce_exec instance
`timescale 1ns/10ps
module ccce_exec_checker #(
    parameter int unsigned DATA_W = 8,
    parameter int unsigned ADDR_W = 8
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [15:0] instrWord,
    input wire logic [DATA_W-1:0] dataRdata,
    input wire logic [ADDR_W-1:0] dataAddr,
    input wire logic dataRdEn,
    input wire logic dataWrEn,
    input wire logic [DATA_W-1:0] dataWdata,
    input wire logic [DATA_W-1:0] workingReg,
    input wire logic timeoutFlagN,
    input wire logic powerdownFlagN,
    input wire logic watchdogClear,
    input wire logic skipNext,
    input wire ccce_pkg::ccce_phase_t phase,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite
);
    import ccce_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // run bit shadow, so stopped cycles do not trip the skip checks
    logic runOn_ff;
    logic nxt_runOn;
    assign nxt_runOn = (regWrite && regAddr == REG_CTRL_OFS) ? regWdata[CTRL_RUN_POS] : runOn_ff;
    // shadow follows software writes to ctrl
    always_ff @(posedge clk_sys) begin
        runOn_ff <= nrst ? nxt_runOn : 1'b1;
    end
    // execute phase of a live compare, one per kind; run bit as seen at decode
    sequence cmpEqRun;
        phase == PH_Q3 && $past(instrWord[15:8], 2) == CMP_EQUAL_TOP8 && !$past(skipNext, 2)
            && $past(runOn_ff, 2);
    endsequence
    sequence cmpGtRun;
        phase == PH_Q3 && $past(instrWord[15:8], 2) == CMP_GREATER_TOP8
            && !$past(skipNext, 2) && $past(runOn_ff, 2);
    endsequence
    // decode slot that follows a skipping compare
    sequence slotDropped;
        phase == PH_Q1 && skipNext;
    endsequence
    a_read_phase_addr: assert property (
        dataRdEn |-> phase == PH_Q2 && dataAddr == $past(instrWord[7:0]))
        else $error("file read outside Q2 or wrong address");
    a_write_phase: assert property (dataWrEn |-> phase == PH_Q4)
        else $error("file write outside Q4");
    a_wdclr_pulse: assert property (
        watchdogClear |-> phase == PH_Q4 && timeoutFlagN && powerdownFlagN ##1 !watchdogClear)
        else $error("watchdog clear pulse or flags wrong");
    a_wdclr_cause: assert property (
        phase == PH_Q4 && $past(instrWord, 3) == WATCHDOG_CLEAR_WORD && !$past(skipNext, 3)
            && $past(runOn_ff, 3) |-> watchdogClear)
        else $error("watchdog clear word not executed");
    a_clear_zero: assert property (
        dataWrEn && $past(instrWord[15:9], 3) == CLEAR_FILE_TOP7 |-> dataWdata == ZERO_BYTE)
        else $error("clear file wrote nonzero");
    a_comp_invert: assert property (
        dataWrEn && $past(instrWord[15:9], 3) == COMPLEMENT_TOP7
            |-> $past(instrWord[8], 3) && dataWdata == ~$past(dataRdata))
        else $error("complement write wrong");
    a_skip_equal: assert property (
        cmpEqRun |=> skipNext == (workingReg == $past(dataRdata)))
        else $error("equal compare skip wrong");
    a_skip_greater: assert property (
        cmpGtRun |=> skipNext == ($past(dataRdata) > workingReg))
        else $error("greater compare skip wrong");
    a_skip_span: assert property (
        $rose(skipNext) |-> phase == PH_Q4 ##0 skipNext [*2] ##1 !skipNext)
        else $error("skip window wrong length");
    a_slot_nop: assert property (
        slotDropped |=> !dataRdEn ##2 !dataWrEn && !watchdogClear)
        else $error("dropped slot did work");
endmodule

bind ccce_exec ccce_exec_checker #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) ccce_exec_checker_i (
    .clk_sys, .nrst, .instrWord, .dataRdata, .dataAddr, .dataRdEn, .dataWrEn, .dataWdata,
    .workingReg, .timeoutFlagN, .powerdownFlagN, .watchdogClear, .skipNext, .phase,
    .regAddr, .regWdata, .regWrite
);

// [tb/testbench.sv]
// self-checking bench for ccce_exec
// assumes a 10 MHz clock and a sync active low reset
`timescale 1ns/10ps
module testbench;
    import ccce_pkg::*;
    localparam logic [3:0] OW = REG_WORK_OFS;
    localparam logic [3:0] OS = REG_STATUS_OFS;
    localparam logic [3:0] OC = REG_CTRL_OFS;
    // register write, word, file value, then expectations
    typedef struct packed {
        logic [3:0] ofs; logic [7:0] w; logic [15:0] word; logic [7:0] f;
        logic [7:0] expW; logic expZ; logic expRd; logic expWr; logic [7:0] expD; logic expSk;
    } ccce_row_t;
    ccce_row_t rows [22] = '{
        '{OW, 8'h00, 16'h1234, 8'h13, 8'hEC, 0, 1, 0, 8'h00, 0},
        '{OW, 8'h55, 16'h13A5, 8'hFF, 8'h55, 1, 1, 1, 8'h00, 0},
        '{OW, 8'h55, 16'h1300, 8'h0F, 8'h55, 0, 1, 1, 8'hF0, 0},
        '{OW, 8'h77, 16'h2940, 8'h5A, 8'h77, 0, 1, 1, 8'h00, 0},
        '{OW, 8'h77, 16'h2840, 8'h5A, 8'h00, 0, 1, 1, 8'h00, 0},
        '{OW, 8'h00, 16'h13C0, 8'hFF, 8'h00, 1, 1, 1, 8'h00, 0},
        '{OW, 8'h42, 16'h3110, 8'h42, 8'h42, 1, 1, 0, 8'h00, 1},
        '{OW, 8'h42, 16'h1200, 8'h00, 8'h42, 1, 0, 0, 8'h00, 0},
        '{OW, 8'h42, 16'h3110, 8'h43, 8'h42, 1, 1, 0, 8'h00, 0},
        '{OW, 8'h42, 16'h3220, 8'h43, 8'h42, 1, 1, 0, 8'h00, 1},
        '{OW, 8'h11, 16'h2830, 8'h5A, 8'h11, 1, 0, 0, 8'h00, 0},
        '{OW, 8'h42, 16'h3220, 8'h42, 8'h42, 1, 1, 0, 8'h00, 0},
        '{OW, 8'h80, 16'h3220, 8'h7F, 8'h80, 1, 1, 0, 8'h00, 0},
        '{OW, 8'h01, 16'h3220, 8'hFF, 8'h01, 1, 1, 0, 8'h00, 1},
        '{OW, 8'h09, 16'h13AA, 8'h00, 8'h09, 1, 0, 0, 8'h00, 0},
        '{OW, 8'h33, 16'h9000, 8'h00, 8'h33, 1, 0, 0, 8'h00, 0},
        '{OS, 8'h00, 16'h0004, 8'h00, 8'h33, 0, 0, 0, 8'h00, 0},
        '{OC, 8'h00, 16'h9000, 8'h00, 8'h33, 0, 0, 0, 8'h00, 0},
        '{OW, 8'h44, 16'h1200, 8'h00, 8'h44, 0, 0, 0, 8'h00, 0},
        '{OC, 8'h01, 16'h9000, 8'h00, 8'h44, 0, 0, 0, 8'h00, 0},
        '{OW, 8'h66, 16'h1200, 8'h00, 8'hFF, 0, 1, 0, 8'h00, 0},
        '{OW, 8'h00, 16'h9000, 8'h00, 8'h00, 0, 0, 0, 8'h00, 0}
    };
    logic clk_sys, nrst, dataRdEn, dataWrEn, zeroFlag, timeoutFlagN, powerdownFlagN;
    logic watchdogClear, skipNext, regWrite, regRead;
    logic [15:0] instrWord;
    logic [7:0] dataRdata, dataAddr, dataWdata, workingReg, regWdata, regRdata, expW;
    logic [3:0] regAddr;
    ccce_phase_t phase;
    int err_total, comparisons, cycles;
    ccce_exec ccce_exec_i (
        .clk_sys, .nrst, .instrWord, .dataRdata, .dataAddr, .dataRdEn, .dataWrEn, .dataWdata,
        .workingReg, .zeroFlag, .timeoutFlagN, .powerdownFlagN, .watchdogClear, .skipNext,
        .phase, .regAddr, .regWdata, .regWrite, .regRead, .regRdata
    );
    // 100 ns period
    always #50 clk_sys = ~clk_sys;
    task automatic chk8(input string n, input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic chk1(input string n, input logic s, input logic e);
        chk8(n, {7'h00, s}, {7'h00, e});
    endtask
    // one instruction cycle, entered at the edge that opens Q1
    task automatic run(input ccce_row_t r);
        instrWord <= r.word;
        regAddr <= r.ofs;
        regWdata <= r.w;
        regWrite <= 1'b1;
        @(negedge clk_sys);
        chk8("workingReg", workingReg, expW);
        chk8("phase", {6'h00, phase}, {6'h00, PH_Q1});
        @(posedge clk_sys);
        regWrite <= 1'b0;
        @(negedge clk_sys);
        chk1("dataRdEn", dataRdEn, r.expRd);
        if (r.expRd) chk8("dataAddr", dataAddr, r.word[7:0]);
        @(posedge clk_sys);
        dataRdata <= r.f;
        @(posedge clk_sys);
        dataRdata <= ~r.f;
        @(negedge clk_sys);
        chk1("dataWrEn", dataWrEn, r.expWr);
        if (r.expWr) chk8("dataWdata", dataWdata, r.expD);
        chk1("skipNext", skipNext, r.expSk);
        chk1("zeroFlag", zeroFlag, r.expZ);
        chk1("timeoutFlagN", timeoutFlagN, 1'b1);
        chk1("powerdownFlagN", powerdownFlagN, 1'b1);
        chk1("watchdogClear", watchdogClear, r.word === WATCHDOG_CLEAR_WORD);
        expW = r.expW;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'b0;
        @(negedge clk_sys);
        chk8("regRdata", regRdata, e);
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask
    task automatic end_of_test;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        clk_sys = 1'b0;
        nrst = 1'b0;
        instrWord = 16'h9000;
        dataRdata = 8'h00;
        regAddr = 4'h0;
        regWdata = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        err_total = 0;
        comparisons = 0;
        cycles = 0;
        expW = WORK_RST;
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        foreach (rows[i]) run(rows[i]);
        // last-op record of the final row, then load state that reset must clear
        rd(REG_LAST_OFS, {5'h00, OP_OUTSIDE});
        wr(OW, 8'h5A);
        wr(OS, 8'h01);
        wr(OC, 8'h00);
        // second reset in mid-run, then register port
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk8("workingReg", workingReg, WORK_RST);
        chk8("phase", {6'h00, phase}, {6'h00, PH_Q1});
        chk1("skipNext", skipNext, 1'b0);
        @(posedge clk_sys);
        nrst <= 1'b1;
        rd(OS, {5'h00, POWERDOWN_N_RST, TIMEOUT_N_RST, ZERO_RST});
        rd(OC, CTRL_RST);
        rd(4'h7, 8'h00);
        wr(OS, 8'h05);
        rd(OS, 8'h05);
        wr(OW, 8'hA5);
        rd(OW, 8'hA5);
        end_of_test();
    end
endmodule
